// [pkg/gpd_pkg.sv]
// package for the gpio port data-control block
package gpd_pkg;
    localparam int unsigned GPD_WIDTH        = 8;
    localparam int unsigned GPD_PORTS        = 8;
    localparam int unsigned GPD_MASK_LSB     = 2;
    // masked data window: byte offsets 0x000..0x3fc
    localparam logic [11:0] GPD_DATA_BASE    = 12'h000;
    localparam logic [11:0] GPD_DATA_LAST    = 12'h3FC;
    // own choices: control words above the data window
    localparam logic [11:0] GPD_DIR_OFF      = 12'h400;
    localparam logic [11:0] GPD_AFSEL_OFF    = 12'h420;
    localparam logic [11:0] GPD_PUR_OFF      = 12'h510;
    localparam logic [11:0] GPD_PDR_OFF      = 12'h514;
    localparam logic [11:0] GPD_DEN_OFF      = 12'h51C;
    localparam logic [11:0] GPD_PORT_STRIDE  = 12'h000;
    localparam int unsigned GPD_PORT_SEL_LSB = 12;
    localparam logic [7:0]  GPD_RST_ZERO     = 8'h00;
    // debug pins: port b bit 7, port c bits 3..0
    localparam logic [7:0]  GPD_DBG_PORT_B   = 8'h80;
    localparam logic [7:0]  GPD_DBG_PORT_C   = 8'h0F;
    localparam int unsigned GPD_PORT_B_IDX   = 1;
    localparam int unsigned GPD_PORT_C_IDX   = 2;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en_n;
    } gpd_pad_drive_t;

    typedef struct packed {
        logic [7:0] afsel;
        logic [7:0] den;
        logic [7:0] pur;
        logic [7:0] pdr;
    } gpd_pad_cfg_t;
endpackage : gpd_pkg

// [logic/gpd_port.sv]
// one 8-bit gpio port: direction, masked data, mode and pad config
//
// Our own choices: the AHB-Lite slave port and the register addresses.
module gpd_port
    import gpd_pkg::*;
#(
    parameter logic [7:0] DBG_MASK = 8'h00
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              clk_en,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    input  wire logic [11:0]       addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata,
    input  wire logic [7:0]        pad_in,
    input  wire logic [7:0]        alt_out,
    input  wire logic [7:0]        alt_out_en_n,
    output gpd_pad_drive_t         pad_drv,
    output gpd_pad_cfg_t           pad_cfg
);
    logic [7:0] pin_direction_bits_q;
    logic [7:0] data_q;
    logic [7:0] alt_function_select_q;
    logic [7:0] digital_input_enable_q;
    logic [7:0] pull_up_select_q;
    logic [7:0] pull_down_select_q;
    logic       is_data;
    logic [7:0] amask;

    assign is_data = (addr <= GPD_DATA_LAST);
    assign amask   = addr[GPD_MASK_LSB +: GPD_WIDTH];

    // input bits follow the pin each cycle, output bits take masked writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= GPD_RST_ZERO;
        end else if (clk_en) begin
            for (int i = 0; i < 8; i++) begin
                if (!pin_direction_bits_q[i]) begin
                    data_q[i] <= pad_in[i];
                end else if (wr_en && is_data && amask[i]) begin
                    data_q[i] <= wdata[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_direction_bits_q   <= GPD_RST_ZERO;
            alt_function_select_q  <= DBG_MASK;
            digital_input_enable_q <= DBG_MASK;
            pull_up_select_q       <= DBG_MASK;
            pull_down_select_q     <= GPD_RST_ZERO;
        end else if (clk_en && wr_en) begin
            case (addr)
                GPD_DIR_OFF:   pin_direction_bits_q   <= wdata;
                GPD_AFSEL_OFF: alt_function_select_q  <= wdata;
                GPD_DEN_OFF:   digital_input_enable_q <= wdata;
                GPD_PUR_OFF:   pull_up_select_q       <= wdata;
                GPD_PDR_OFF:   pull_down_select_q     <= wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata <= GPD_RST_ZERO;
        end else if (clk_en && rd_en) begin
            if (is_data) begin
                rdata <= data_q & amask;
            end else begin
                case (addr)
                    GPD_DIR_OFF:   rdata <= pin_direction_bits_q;
                    GPD_AFSEL_OFF: rdata <= alt_function_select_q;
                    GPD_DEN_OFF:   rdata <= digital_input_enable_q;
                    GPD_PUR_OFF:   rdata <= pull_up_select_q;
                    GPD_PDR_OFF:   rdata <= pull_down_select_q;
                    default:       rdata <= GPD_RST_ZERO;
                endcase
            end
        end
    end

    // pad drive registered so top outputs come from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_drv <= '{out_val: 8'h00, out_en_n: 8'hFF};
            pad_cfg <= '{afsel: DBG_MASK, den: DBG_MASK, pur: DBG_MASK, pdr: 8'h00};
        end else if (clk_en) begin
            for (int i = 0; i < 8; i++) begin
                if (alt_function_select_q[i]) begin
                    pad_drv.out_val[i]  <= alt_out[i];
                    pad_drv.out_en_n[i] <= alt_out_en_n[i];
                end else begin
                    pad_drv.out_val[i]  <= data_q[i];
                    pad_drv.out_en_n[i] <= ~pin_direction_bits_q[i];
                end
            end
            pad_cfg <= '{afsel: alt_function_select_q, den: digital_input_enable_q,
                         pur: pull_up_select_q, pdr: pull_down_select_q};
        end
    end
endmodule : gpd_port

// [logic/gpd_top.sv]
// eight gpio ports behind one ahb-lite slave
// Overview of operation
// - ordinary pins reset undriven; alt select, enable, pulls cleared
// - port b bit 7 and port c bits 3..0 reset to debug function
// - any reset, power-on or pin, restores all defaults
// - eight instances of one port module, ports b and c with their own debug reset mask
// - direction zero: data bit captures the pin level
// - direction one: pin driven from the data bit
// - data register spans 256 words, address bits 9..2 mask
// - masked write changes only bits whose mask bit is one
// - masked read returns zero for bits whose mask bit is zero
// - alternate select hands the pin to its peripheral
module gpd_top
    import gpd_pkg::*;
(
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      clk_en,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic [GPD_PORTS*8-1:0]    pad_in,
    input  wire logic [GPD_PORTS*8-1:0]    alt_out,
    input  wire logic [GPD_PORTS*8-1:0]    alt_out_en_n,
    output gpd_pad_drive_t [GPD_PORTS-1:0] pad_drv,
    output gpd_pad_cfg_t   [GPD_PORTS-1:0] pad_cfg
);
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [14:0] addr_q;
    logic [7:0]  rd_port [GPD_PORTS];
    logic        take;

    assign take = hsel && hready && htrans[1];

    // write data arrives one cycle after the address, so the address is held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 15'h0000;
        end else if (clk_en) begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                addr_q <= haddr[14:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            // a read holds the bus for two cycles: the port flop first, then the hrdata flop
            hreadyout <= !(take && !hwrite) && !rd_pend_q;
            hresp     <= 1'b0;
        end
    end

    // hrdata is loaded one edge after the port flop, and the bus waits for it
    logic rd_done_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_q <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else if (clk_en) begin
            rd_done_q <= rd_pend_q;
            if (rd_done_q) begin
                hrdata <= {24'h00_0000, rd_port[addr_q[14:12]]};
            end
        end
    end

    for (genvar p = 0; p < GPD_PORTS; p++) begin : g_port
        localparam logic [7:0] DBG = (p == GPD_PORT_B_IDX) ? GPD_DBG_PORT_B :
                                     (p == GPD_PORT_C_IDX) ? GPD_DBG_PORT_C : 8'h00;
        gpd_port #(.DBG_MASK(DBG)) u_port (
            .hclk         (hclk),
            .hresetn      (hresetn),
            .clk_en       (clk_en),
            .wr_en        (wr_pend_q && (addr_q[14:12] == 3'(p))),
            .rd_en        (rd_pend_q && (addr_q[14:12] == 3'(p))),
            .addr         (addr_q[11:0]),
            .wdata        (hwdata[7:0]),
            .rdata        (rd_port[p]),
            .pad_in       (pad_in[p*8 +: 8]),
            .alt_out      (alt_out[p*8 +: 8]),
            .alt_out_en_n (alt_out_en_n[p*8 +: 8]),
            .pad_drv      (pad_drv[p]),
            .pad_cfg      (pad_cfg[p])
        );
    end
endmodule : gpd_top

// [sim/gpd_pad_model.sv]
// pad model: driven pins echo the port, released pins show the bench's pattern, except port b bit 7 held high in reset
module gpd_pad_model
    import gpd_pkg::*;
(
    input  wire logic                           hresetn,
    input  wire logic [GPD_PORTS*8-1:0]         ext,
    input  wire gpd_pad_drive_t [GPD_PORTS-1:0] pad_drv,
    output logic      [GPD_PORTS*8-1:0]         pad_in
);
    always_comb begin
        for (int p = 0; p < GPD_PORTS; p++) begin
            pad_in[p*8+:8] = (ext[p*8+:8] & pad_drv[p].out_en_n) | (pad_drv[p].out_val & ~pad_drv[p].out_en_n);
        end
        // a low here would reset the debug controller
        if (!hresetn) begin
            pad_in[15] = 1'b1;
        end
    end
endmodule : gpd_pad_model

// [sim/gpd_top_properties.sv]
// concurrent checks on the pins of the gpio port block
module gpd_top_chk
    import gpd_pkg::*;
(
    input wire logic                           hclk,
    input wire logic                           hresetn,
    input wire logic                           hsel,
    input wire logic [1:0]                     htrans,
    input wire logic                           hwrite,
    input wire logic [31:0]                    hrdata,
    input wire logic                           hreadyout,
    input wire logic                           hresp,
    input wire gpd_pad_drive_t [GPD_PORTS-1:0] pad_drv,
    input wire gpd_pad_cfg_t   [GPD_PORTS-1:0] pad_cfg
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    okay_resp_a: assert property (hresp == 1'b0) else $error("bad response");
    zero_wait_a: assert property (hsel && htrans[1] && hwrite && hreadyout |=> hreadyout)
        else $error("write wait state");
    read_wait_a: assert property (hsel && htrans[1] && !hwrite && hreadyout |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("read wait states");
    upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000) else $error("upper bits set");
    ord_clear_a: assert property ($rose(hresetn) |-> pad_cfg[0] == 32'h0000_0000) else $error("port 0 cfg");
    dbg_b_a: assert property ($rose(hresetn) |-> pad_cfg[1] == {{3{GPD_DBG_PORT_B}}, GPD_RST_ZERO})
        else $error("port b debug cfg");
    dbg_c_a: assert property ($rose(hresetn) |-> pad_cfg[2] == {{3{GPD_DBG_PORT_C}}, GPD_RST_ZERO})
        else $error("port c debug cfg");
    far_undriven_a: assert property ($rose(hresetn) |-> pad_drv[7] == 16'h00FF && pad_cfg[7] == '0)
        else $error("port 7 not default");
    cfg_hold_a: assert property (!(hsel && htrans[1] && hwrite) [*5] |=> $stable(pad_cfg))
        else $error("cfg moved without write");
endmodule : gpd_top_chk

bind gpd_top gpd_top_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_drv(pad_drv), .pad_cfg(pad_cfg));

// [sim/tb_gpio_port_data_control.sv]
// self-checking bench for the gpio port data-control block
module tb_gpio_port_data_control import gpd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_s;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [63:0] pad_in, alt_out, alt_en_n, ext;
    logic [7:0] o, w, m;
    gpd_pad_drive_t [GPD_PORTS-1:0] pad_drv;
    gpd_pad_cfg_t [GPD_PORTS-1:0] pad_cfg;
    int error_cnt, tests_run;
    gpd_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .alt_out(alt_out), .alt_out_en_n(alt_en_n),
        .pad_drv(pad_drv), .pad_cfg(pad_cfg));
    gpd_pad_model pad_u (.hresetn(hresetn), .ext(ext), .pad_drv(pad_drv), .pad_in(pad_in));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // hready is registered, so its mid-cycle value is what the next edge samples
    always @(negedge hclk) rdy_s <= hreadyout;
    function automatic logic [7:0] dbg(int p);
        return (p == GPD_PORT_B_IDX) ? GPD_DBG_PORT_B : (p == GPD_PORT_C_IDX) ? GPD_DBG_PORT_C : GPD_RST_ZERO;
    endfunction : dbg
    function automatic logic [7:0] mrg(logic [7:0] old, logic [7:0] nw, logic [7:0] msk);
        return (old & ~msk) | (nw & msk);
    endfunction : mrg
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_s !== 1'b1 && n < 64);
        if (rdy_s !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input int p, input logic [11:0] off, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= (32'(p) << 12) | 32'(off);
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_rdy();
        // read data is taken at the edge that ends the data phase
        r = hrdata;
    endtask : bus
    task automatic dflt();
        @(negedge hclk);
        for (int p = 0; p < GPD_PORTS; p++) begin
            chk({pad_cfg[p], pad_drv[p]}, {{3{dbg(p)}}, GPD_RST_ZERO, 16'h00FF});
        end
        @(posedge hclk);
    endtask : dflt
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        error_cnt = 0;
        tests_run = 0;
        alt_out = '0;
        alt_en_n = '1;
        ext = '0;
        void'($urandom(32'he5b2));
        repeat (3) @(posedge hclk);
        dflt();
        hresetn <= 1'b1;
        for (int p = 0; p < GPD_PORTS; p++) begin
            o = $urandom;
            w = $urandom;
            m = $urandom;
            bus(1'b1, p, GPD_DIR_OFF, 8'hFF);
            bus(1'b1, p, GPD_DATA_LAST, o);
            bus(1'b1, p, {2'b00, m, 2'b00}, w);
            bus(1'b0, p, GPD_DATA_LAST, 8'h00);
            chk(r, mrg(o, w, m));
            bus(1'b0, p, {2'b00, ~m, 2'b00}, 8'h00);
            chk(r, mrg(o, w, m) & ~m);
            @(negedge hclk);
            chk(pad_drv[p], {mrg(o, w, m) & ~dbg(p), dbg(p)});
            ext[p*8+:8] = $urandom;
            @(posedge hclk);
            bus(1'b1, p, GPD_DIR_OFF, 8'h00);
            // the pad turns around one edge after the direction, and the data bit follows it an edge later
            repeat (2) @(posedge hclk);
            bus(1'b0, p, {2'b00, m, 2'b00}, 8'h00);
            chk(r, ext[p*8+:8] & m);
        end
        $display("data path test done");
        @(posedge hclk);
        alt_out <= {$urandom, $urandom};
        alt_en_n <= {$urandom, $urandom};
        bus(1'b1, 3, GPD_AFSEL_OFF, 8'hFF);
        bus(1'b1, 3, GPD_DEN_OFF, o);
        bus(1'b1, 3, GPD_PUR_OFF, w);
        bus(1'b1, 3, GPD_PDR_OFF, m);
        bus(1'b0, 3, 12'h800, 8'h00);
        chk(r, 48'h0000_0000_0000);
        @(negedge hclk);
        chk({pad_cfg[3], pad_drv[3]}, {8'hFF, o, w, m, alt_out[31:24], alt_en_n[31:24]});
        @(posedge hclk);
        $display("alternate test done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        dflt();
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        $display("reset test done");
        end_of_test();
    end
endmodule : tb_gpio_port_data_control
